//--- t2fcs_pkg.sv
// Constants, types and register map for the tributary framer control and status bank
// Summary of operation
// - T3: remote alarm control sends X bit inverted
// - E3: remote alarm control drives frame bit 11
// - G.747: remote alarm control drives Set 2 bit 1
// - All-ones control replaces tributary data with ones
// - Inject bit rising edge starts one error burst
// - T3: burst corrupts four consecutive F bits
// - E3: four inverted ten-bit alignment words sent
// - G.747: four inverted nine-bit alignment words sent
// - E3 only: national bit controls force outgoing bits
// - Frame loss latch sets, read clears unless present
// - Frame loss change feeds summary one when enabled
// - All-ones latch sets, read clears unless present
// - All-ones change feeds summary one when enabled
// - Remote alarm latch sets, read clears unless present
// - Remote alarm change feeds summary two when enabled
// - E3 received national bits loaded each frame start
// - Frame start events latch, clear on read, no interrupt
// - Reading status one clears its summary path latches
// - T2 frame loss: 2 of 5 F or 2 of 4 M errors
// - E2/G.747 frame loss: 4 bad set, 3 good clear
// - T2 remote alarm: four M frames X zero or one
// - E2 all-ones: two frames of few zeros
package t2fcs_pkg;

  typedef enum logic [2:0] {
    T2FCS_MODE_T3 = 3'h1,
    T2FCS_MODE_E3 = 3'h2,
    T2FCS_MODE_G747 = 3'h4
  } t2fcs_mode_t;

  localparam int TRIB_N = 7;
  localparam int E2_N = 4;

  // Printed offsets are register indices; byte address is four times that
  localparam logic [7:0] IDX_TX_ALARM = 8'h30;
  localparam logic [7:0] IDX_INJECT = 8'h32;
  localparam logic [7:0] IDX_STATUS_ONE = 8'h34;
  localparam logic [7:0] IDX_STATUS_TWO = 8'h36;
  localparam logic [7:0] ADDR_TX_ALARM = 8'h00C0;
  localparam logic [7:0] ADDR_INJECT = 8'h00C8;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h00D0;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h00D8;

  localparam int LO_BASE = 0;
  localparam int HI_BASE = 8;
  localparam int IE_LOF_BIT = 7;
  localparam int IE_AIS_BIT = 15;
  localparam int IE_RAI_BIT = 7;
  localparam int NAT_BASE = 8;
  localparam int SOF_BASE = 12;

  localparam logic [15:0] TX_ALARM_WMASK = 16'h7F7F;
  localparam logic [15:0] INJECT_WMASK = 16'h0F7F;
  localparam logic [15:0] STATUS_ONE_WMASK = 16'h8080;
  localparam logic [15:0] STATUS_TWO_WMASK = 16'h0080;
  localparam logic [15:0] REG_RESET = 16'h0000;

  localparam logic [2:0] BURST_LEN = 3'h4;
  localparam logic [2:0] FAS_BAD_SET = 3'h4;
  localparam logic [2:0] FAS_GOOD_CLR = 3'h3;
  localparam logic [2:0] RAI_RUN = 3'h4;
  localparam logic [3:0] AIS_T2_MAX_ZEROS = 4'h8;
  localparam logic [1:0] AIS_T2_WINDOWS = 2'h1;
  localparam logic [3:0] AIS_E2_MAX_ZEROS = 4'h4;
  localparam logic [1:0] AIS_E2_WINDOWS = 2'h2;
  localparam logic [2:0] LOF_ERR_MIN = 3'h2;

  localparam logic [9:0] E2_FAS = 10'h3D0;
  localparam logic [8:0] G747_FAS = 9'h1D0;

endpackage

//--- t2fcs_regs.sv
// APB register bank, alarm detectors and transmit controls for seven tributary framers
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module t2fcs_regs #(
  parameter int ZW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire t2fcs_pkg::t2fcs_mode_t mode,
  input wire logic [6:0] tx_align_stb,
  output logic [6:0] tx_xbit,
  output logic [6:0] tx_rai_bit,
  output logic [6:0] tx_all_ones,
  output logic [6:0] tx_align_invert,
  output logic [69:0] tx_fas_word,
  output logic [3:0] tx_national_bits,
  output logic tx_national_force,
  input wire logic [6:0] rx_fbit_stb,
  input wire logic [6:0] rx_fbit_err,
  input wire logic [6:0] rx_mbit_stb,
  input wire logic [6:0] rx_mbit_err,
  input wire logic [6:0] rx_resync,
  input wire logic [6:0] rx_fas_stb,
  input wire logic [6:0] rx_fas_good,
  input wire logic [6:0] rx_rai_stb,
  input wire logic [6:0] rx_rai_val,
  input wire logic [6:0] rx_ais_stb,
  input wire logic [7*ZW-1:0] rx_ais_zeros,
  input wire logic [3:0] rx_sof_stb,
  input wire logic [3:0] rx_national_bit,
  output logic summary_one,
  output logic summary_two
);

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] wd,
                                       input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    wr16 = (old & ~m) | (wd[15:0] & m);
  endfunction

  function automatic logic two_or_more(input logic [4:0] h);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < 5; k++)
    begin
      n = n + {2'h0, h[k]};
    end
    two_or_more = (n >= t2fcs_pkg::LOF_ERR_MIN);
  endfunction

  logic [15:0] tx_alarm_q;
  logic [15:0] inject_q;
  logic [15:0] ie_one_q;
  logic [15:0] ie_two_q;
  logic [31:0] prdata_q;
  logic [6:0] lof_now;
  logic [6:0] ais_now;
  logic [6:0] rai_now;
  logic [6:0] lof_seen_q;
  logic [6:0] ais_seen_q;
  logic [6:0] rai_seen_q;
  logic [6:0] lof_lat_q;
  logic [6:0] ais_lat_q;
  logic [6:0] rai_lat_q;
  logic [3:0] sof_lat_q;
  logic [3:0] nat_rx_q;
  logic sum_one_q;
  logic sum_two_q;
  logic [3:0] tx_nat_q;
  logic tx_nat_force_q;
  logic setup;
  logic access;
  logic hit;
  logic wr;
  logic rd_one;
  logic rd_two;
  logic [31:0] rd_val;
  logic is_t3;
  logic is_e3;

  assign is_t3 = (mode == t2fcs_pkg::T2FCS_MODE_T3);
  assign is_e3 = (mode == t2fcs_pkg::T2FCS_MODE_E3);

  // Bus slave: read data captured in setup, access always completes at once
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = (paddr == t2fcs_pkg::ADDR_TX_ALARM) || (paddr == t2fcs_pkg::ADDR_INJECT) ||
               (paddr == t2fcs_pkg::ADDR_STATUS_ONE) || (paddr == t2fcs_pkg::ADDR_STATUS_TWO);
  assign wr = pce & access & pwrite & hit;
  assign rd_one = pce & access & ~pwrite & (paddr == t2fcs_pkg::ADDR_STATUS_ONE);
  assign rd_two = pce & access & ~pwrite & (paddr == t2fcs_pkg::ADDR_STATUS_TWO);
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = prdata_q;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      t2fcs_pkg::ADDR_TX_ALARM: rd_val[15:0] = tx_alarm_q;
      t2fcs_pkg::ADDR_INJECT: rd_val[15:0] = inject_q;
      t2fcs_pkg::ADDR_STATUS_ONE: rd_val[15:0] = ie_one_q | {1'b0, ais_lat_q, 1'b0, lof_lat_q};
      t2fcs_pkg::ADDR_STATUS_TWO: rd_val[15:0] = ie_two_q | {sof_lat_q, nat_rx_q, 1'b0, rai_lat_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (pce && setup)
      prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
  end

  // Writable fields only; latched status bits are read-only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_alarm_q <= t2fcs_pkg::REG_RESET;
      inject_q <= t2fcs_pkg::REG_RESET;
      ie_one_q <= t2fcs_pkg::REG_RESET;
      ie_two_q <= t2fcs_pkg::REG_RESET;
    end
    else if (wr)
    begin
      if (paddr == t2fcs_pkg::ADDR_TX_ALARM)
        tx_alarm_q <= wr16(tx_alarm_q, pwdata, pstrb, t2fcs_pkg::TX_ALARM_WMASK);
      if (paddr == t2fcs_pkg::ADDR_INJECT)
        inject_q <= wr16(inject_q, pwdata, pstrb, t2fcs_pkg::INJECT_WMASK);
      if (paddr == t2fcs_pkg::ADDR_STATUS_ONE)
        ie_one_q <= wr16(ie_one_q, pwdata, pstrb, t2fcs_pkg::STATUS_ONE_WMASK);
      if (paddr == t2fcs_pkg::ADDR_STATUS_TWO)
        ie_two_q <= wr16(ie_two_q, pwdata, pstrb, t2fcs_pkg::STATUS_TWO_WMASK);
    end
  end

  // Only bits the host actually saw are cleared, so an event between
  // the setup snapshot and the access edge survives; set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lof_lat_q <= 7'h00;
      ais_lat_q <= 7'h00;
    end
    else if (pce)
    begin
      lof_lat_q <= lof_now | (lof_lat_q & ~({7{rd_one}} & prdata_q[6:0]));
      ais_lat_q <= ais_now | (ais_lat_q & ~({7{rd_one}} & prdata_q[14:8]));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rai_lat_q <= 7'h00;
      sof_lat_q <= 4'h0;
      nat_rx_q <= 4'h0;
    end
    else if (pce)
    begin
      rai_lat_q <= rai_now | (rai_lat_q & ~({7{rd_two}} & prdata_q[6:0]));
      sof_lat_q <= rx_sof_stb | (sof_lat_q & ~({4{rd_two}} & prdata_q[15:12]));
      for (int n = 0; n < t2fcs_pkg::E2_N; n++)
      begin
        if (rx_sof_stb[n])
          nat_rx_q[n] <= rx_national_bit[n];
      end
    end
  end

  // Summary outputs feed the master status logic outside; no local interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lof_seen_q <= 7'h00;
      ais_seen_q <= 7'h00;
      rai_seen_q <= 7'h00;
      sum_one_q <= 1'b0;
      sum_two_q <= 1'b0;
    end
    else if (pce)
    begin
      lof_seen_q <= lof_now;
      ais_seen_q <= ais_now;
      rai_seen_q <= rai_now;
      sum_one_q <= ((|(lof_now ^ lof_seen_q)) & ie_one_q[t2fcs_pkg::IE_LOF_BIT]) |
                   ((|(ais_now ^ ais_seen_q)) & ie_one_q[t2fcs_pkg::IE_AIS_BIT]) |
                   (sum_one_q & ~rd_one);
      sum_two_q <= ((|(rai_now ^ rai_seen_q)) & ie_two_q[t2fcs_pkg::IE_RAI_BIT]) |
                   (sum_two_q & ~rd_two);
    end
  end

  assign summary_one = sum_one_q;
  assign summary_two = sum_two_q;

  // National bits only go out in E3; other modes ignore the controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_nat_q <= 4'h0;
      tx_nat_force_q <= 1'b0;
    end
    else if (pce)
    begin
      tx_nat_q <= is_e3 ? inject_q[t2fcs_pkg::NAT_BASE +: 4] : 4'h0;
      tx_nat_force_q <= is_e3;
    end
  end

  assign tx_national_bits = tx_nat_q;
  assign tx_national_force = tx_nat_force_q;

  for (genvar i = 0; i < t2fcs_pkg::TRIB_N; i++)
  begin : g_trib
    logic lof_q;
    logic ais_q;
    logic rai_q;
    logic [4:0] fh_q;
    logic [3:0] mh_q;
    logic [2:0] fas_cnt_q;
    logic [2:0] rai_cnt_q;
    logic [1:0] ais_cnt_q;
    logic [2:0] burst_q;
    logic inj_prev_q;
    logic ais_low;
    logic [1:0] ais_need;
    logic [ZW-1:0] zeros;

    assign zeros = rx_ais_zeros[i*ZW +: ZW];
    assign ais_low = is_t3 ? (zeros <= ZW'(t2fcs_pkg::AIS_T2_MAX_ZEROS)) :
                             (zeros <= ZW'(t2fcs_pkg::AIS_E2_MAX_ZEROS));
    assign ais_need = is_t3 ? t2fcs_pkg::AIS_T2_WINDOWS : t2fcs_pkg::AIS_E2_WINDOWS;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        lof_q <= 1'b0;
        fh_q <= 5'h00;
        mh_q <= 4'h0;
        fas_cnt_q <= 3'h0;
      end
      else if (pce)
      begin
        if (is_t3)
        begin
          fas_cnt_q <= 3'h0;
          if (rx_resync[i])
          begin
            lof_q <= 1'b0;
            fh_q <= 5'h00;
            mh_q <= 4'h0;
          end
          else
          begin
            if (rx_fbit_stb[i])
              fh_q <= {fh_q[3:0], rx_fbit_err[i]};
            if (rx_mbit_stb[i])
              mh_q <= {mh_q[2:0], rx_mbit_err[i]};
            if (two_or_more(fh_q) || two_or_more({1'b0, mh_q}))
              lof_q <= 1'b1;
          end
        end
        else if (rx_fas_stb[i])
        begin
          if (lof_q == rx_fas_good[i])
          begin
            if (fas_cnt_q == (lof_q ? t2fcs_pkg::FAS_GOOD_CLR : t2fcs_pkg::FAS_BAD_SET) - 3'h1)
            begin
              lof_q <= ~lof_q;
              fas_cnt_q <= 3'h0;
            end
            else
              fas_cnt_q <= fas_cnt_q + 3'h1;
          end
          else
            fas_cnt_q <= 3'h0;
        end
      end
    end

    // Active level normalised: T2 alarm is X low, E2/G.747 alarm bit high
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rai_q <= 1'b0;
        rai_cnt_q <= 3'h0;
      end
      else if (pce && rx_rai_stb[i])
      begin
        if ((is_t3 ? ~rx_rai_val[i] : rx_rai_val[i]) != rai_q)
        begin
          if (rai_cnt_q == t2fcs_pkg::RAI_RUN - 3'h1)
          begin
            rai_q <= ~rai_q;
            rai_cnt_q <= 3'h0;
          end
          else
            rai_cnt_q <= rai_cnt_q + 3'h1;
        end
        else
          rai_cnt_q <= 3'h0;
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ais_q <= 1'b0;
        ais_cnt_q <= 2'h0;
      end
      else if (pce && rx_ais_stb[i])
      begin
        if (ais_low != ais_q)
        begin
          if (ais_cnt_q == ais_need - 2'h1)
          begin
            ais_q <= ~ais_q;
            ais_cnt_q <= 2'h0;
          end
          else
            ais_cnt_q <= ais_cnt_q + 2'h1;
        end
        else
          ais_cnt_q <= 2'h0;
      end
    end

    // Burst counts alignment slots: F bits in T3, alignment words otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        inj_prev_q <= 1'b0;
        burst_q <= 3'h0;
      end
      else if (pce)
      begin
        inj_prev_q <= inject_q[t2fcs_pkg::LO_BASE + i];
        if (inject_q[t2fcs_pkg::LO_BASE + i] && !inj_prev_q)
          burst_q <= t2fcs_pkg::BURST_LEN;
        else if (tx_align_stb[i] && burst_q != 3'h0)
          burst_q <= burst_q - 3'h1;
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        tx_xbit[i] <= 1'b1;
        tx_rai_bit[i] <= 1'b0;
        tx_all_ones[i] <= 1'b0;
        tx_fas_word[i*10 +: 10] <= 10'h000;
      end
      else if (pce)
      begin
        tx_xbit[i] <= ~tx_alarm_q[t2fcs_pkg::LO_BASE + i];
        tx_rai_bit[i] <= tx_alarm_q[t2fcs_pkg::LO_BASE + i];
        tx_all_ones[i] <= tx_alarm_q[t2fcs_pkg::HI_BASE + i];
        if (is_e3)
          tx_fas_word[i*10 +: 10] <= (burst_q != 3'h0) ? ~t2fcs_pkg::E2_FAS : t2fcs_pkg::E2_FAS;
        else if (mode == t2fcs_pkg::T2FCS_MODE_G747)
          tx_fas_word[i*10 +: 10] <= {1'b0, (burst_q != 3'h0) ? ~t2fcs_pkg::G747_FAS : t2fcs_pkg::G747_FAS};
        else
          tx_fas_word[i*10 +: 10] <= 10'h000;
      end
    end

    assign tx_align_invert[i] = (burst_q != 3'h0);
    assign lof_now[i] = lof_q;
    assign ais_now[i] = ais_q;
    assign rai_now[i] = rai_q;
  end

endmodule

//--- t2fcs_properties.sv
// Checker for the tributary framer register bank
`timescale 1ns/100ps
module t2fcs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire t2fcs_pkg::t2fcs_mode_t mode,
  input wire logic [6:0] tx_align_stb,
  input wire logic [6:0] tx_xbit,
  input wire logic [6:0] tx_rai_bit,
  input wire logic [6:0] tx_all_ones,
  input wire logic [6:0] tx_align_invert,
  input wire logic [69:0] tx_fas_word,
  input wire logic [3:0] tx_national_bits,
  input wire logic tx_national_force,
  input wire logic summary_one
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [2:0] burst_cnt_q;
  logic acc, mapped, inv0, inj_wr;
  logic [6:0] ones_d;
  assign acc = psel && penable;
  assign mapped = paddr inside {t2fcs_pkg::ADDR_TX_ALARM, t2fcs_pkg::ADDR_INJECT, t2fcs_pkg::ADDR_STATUS_ONE,
    t2fcs_pkg::ADDR_STATUS_TWO};
  assign inv0 = tx_align_invert[0];
  assign ones_d = pwdata[14:8];
  assign inj_wr = acc && pwrite && paddr == t2fcs_pkg::ADDR_INJECT && pwdata[0] && pstrb[0];
  // Strobes seen while the first tributary's burst runs
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      burst_cnt_q <= 3'h0;
    else if (!inv0)
      burst_cnt_q <= 3'h0;
    else if (tx_align_stb[0])
      burst_cnt_q <= burst_cnt_q + 3'h1;
  a_xbit_inverse: assert property (tx_xbit == ~tx_rai_bit)
    else $error("X bit is not the inverse of the alarm bit");
  a_ones_follow: assert property (acc && pwrite && paddr == t2fcs_pkg::ADDR_TX_ALARM && pstrb[1]
    |=> ##1 tx_all_ones == $past(ones_d, 2)) else $error("All-ones outputs differ from written value");
  a_slverr_map: assert property (acc |-> pslverr == !mapped)
    else $error("Error response does not match the address map");
  a_upper_zero: assert property (psel && !penable |=> prdata[31:16] == 16'h0000)
    else $error("Upper read data not zero");
  a_national_e3: assert property ($past(presetn) |-> tx_national_force == ($past(mode) == t2fcs_pkg::T2FCS_MODE_E3)
    && (tx_national_force || tx_national_bits == 4'h0)) else $error("National bits driven outside E3");
  a_burst_four: assert property ($fell(tx_align_invert[0]) |-> burst_cnt_q == 3'h4)
    else $error("Burst did not span four alignment slots");
  a_inject_cause: assert property ($rose(tx_align_invert[0]) |-> $past(inj_wr, 2))
    else $error("Burst started without an inject write");
  a_fas_e3: assert property (mode == t2fcs_pkg::T2FCS_MODE_E3
    |=> tx_fas_word[9:0] == (t2fcs_pkg::E2_FAS ^ {10{$past(inv0)}})) else $error("E3 alignment word wrong");
  a_fas_g747: assert property (mode == t2fcs_pkg::T2FCS_MODE_G747
    |=> tx_fas_word[9:0] == {1'b0, t2fcs_pkg::G747_FAS ^ {9{$past(inv0)}}}) else $error("G747 alignment word wrong");
  c_burst: cover property ($rose(tx_align_invert[0]));
  c_summary: cover property ($rose(summary_one));
  c_refused: cover property (acc && pslverr);
endmodule
bind t2fcs_regs t2fcs_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pslverr, .mode, .tx_align_stb, .tx_xbit, .tx_rai_bit, .tx_all_ones, .tx_align_invert, .tx_fas_word,
  .tx_national_bits, .tx_national_force, .summary_one);

//--- t2fcs_host.sv
// Host processor model on the control port
`timescale 1ns/100ps
module t2fcs_host (
  input wire logic pclk,
  input wire logic pready,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000,
  output logic [3:0] pstrb = 4'hF,
  output logic hang = 1'b0
);
  // Request held until pready is seen at an edge; bounded so a dead slave is reported
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      hang <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- t2fcs_regs_bench.sv
// Self-checking bench for the tributary framer register bank
`timescale 1ns/100ps
module t2fcs_regs_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, hang, summary_one, summary_two, tx_national_force;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, tx_national_bits;
  logic [6:0] tx_xbit, tx_rai_bit, tx_all_ones, tx_align_invert;
  logic [6:0] tx_align_stb = '0, rx_fas_stb = '0, rx_fas_good = '0, rx_rai_stb = '0, rx_rai_val = '0;
  logic [6:0] rx_ais_stb = '0;
  logic [3:0] rx_sof_stb = '0, rx_national_bit = '0;
  logic [69:0] tx_fas_word;
  t2fcs_pkg::t2fcs_mode_t mode = t2fcs_pkg::T2FCS_MODE_T3;
  logic [31:0] lfsr = 32'h0000_0BCE;
  logic [31:0] rd_q[$];
  int miscompares = 0;
  int total_checks = 0;
  initial forever #12.5 pclk = ~pclk;
  t2fcs_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .hang(hang));
  t2fcs_regs #(.ZW(4)) dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode(mode), .tx_align_stb(tx_align_stb), .tx_xbit(tx_xbit), .tx_rai_bit(tx_rai_bit),
    .tx_all_ones(tx_all_ones), .tx_align_invert(tx_align_invert), .tx_fas_word(tx_fas_word),
    .tx_national_bits(tx_national_bits), .tx_national_force(tx_national_force), .rx_fbit_stb(7'h00),
    .rx_fbit_err(rx_fas_good), .rx_mbit_stb(7'h00), .rx_mbit_err(rx_fas_good), .rx_resync(7'h00),
    .rx_fas_stb(rx_fas_stb), .rx_fas_good(rx_fas_good), .rx_rai_stb(rx_rai_stb), .rx_rai_val(rx_rai_val),
    .rx_ais_stb(rx_ais_stb), .rx_ais_zeros(lfsr[27:0]), .rx_sof_stb(rx_sof_stb),
    .rx_national_bit(rx_national_bit),
    .summary_one(summary_one), .summary_two(summary_two));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  // Each strobe lasts one cycle with a gap, then two settling edges
  task stb(input int n, input logic [6:0] tx, input logic [6:0] fas, input logic [6:0] good, input logic [6:0] rai,
    input logic [6:0] val);
    repeat (n)
    begin
      @(posedge pclk);
      {tx_align_stb, rx_fas_stb, rx_fas_good, rx_rai_stb, rx_rai_val} <= {tx, fas, good, rai, val};
      @(posedge pclk);
      {tx_align_stb, rx_fas_stb, rx_rai_stb} <= 21'h0;
    end
    repeat (2) @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1)
      chk(prdata, rd_q.pop_front());
  always @(posedge pclk)
    if (hang === 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    logic [15:0] d;
    logic [6:0] ais_exp;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(t2fcs_pkg::ADDR_TX_ALARM + 8'(8 * i), 32'h0000_0000);
    rd(8'hC4, 32'h0000_0000);
    chk(32'(tx_xbit), 32'h0000_007F);
    $display("Test reset values done");
    for (int m = 0; m < 3; m++)
    begin
      mode <= t2fcs_pkg::t2fcs_mode_t'(3'h1 << m);
      lfsr <= next_rand(next_rand(lfsr));
      @(posedge pclk);
      d = lfsr[15:0] & (m == 1 ? 16'h0F0F : 16'hFFFF);
      host.xfer(1'b1, t2fcs_pkg::ADDR_TX_ALARM, {16'h0000, d});
      rd(t2fcs_pkg::ADDR_TX_ALARM, {16'h0000, d & t2fcs_pkg::TX_ALARM_WMASK});
      chk(32'(tx_xbit), {25'h0, ~d[6:0]});
      chk(32'(tx_rai_bit), 32'(d[6:0]));
      chk(32'(tx_all_ones), 32'(d[14:8]));
    end
    $display("Test transmit controls done");
    // National bit controls only go out in E3
    mode <= t2fcs_pkg::T2FCS_MODE_E3;
    host.xfer(1'b1, t2fcs_pkg::ADDR_TX_ALARM, 32'h0000_0000);
    host.xfer(1'b1, t2fcs_pkg::ADDR_INJECT, 32'h0000_0A01);
    repeat (2) @(posedge pclk);
    chk(32'(tx_align_invert), 32'h0000_0001);
    chk(32'(tx_national_bits), 32'h0000_000A);
    stb(4, 7'h01, 7'h00, 7'h00, 7'h00, 7'h00);
    chk(32'(tx_align_invert), 32'h0000_0000);
    stb(2, 7'h01, 7'h00, 7'h00, 7'h00, 7'h00);
    chk(32'(tx_align_invert), 32'h0000_0000);
    host.xfer(1'b1, t2fcs_pkg::ADDR_INJECT, 32'h0000_0A00);
    host.xfer(1'b1, t2fcs_pkg::ADDR_INJECT, 32'h0000_0A81);
    stb(4, 7'h01, 7'h00, 7'h00, 7'h00, 7'h00);
    rd(t2fcs_pkg::ADDR_INJECT, 32'h0000_0A01);
    $display("Test error injection done");
    host.xfer(1'b1, t2fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0080);
    stb(4, 7'h00, 7'h01, 7'h00, 7'h00, 7'h00);
    chk(32'(summary_one), 32'h0000_0001);
    rd(t2fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0081);
    rd(t2fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0081);
    stb(3, 7'h00, 7'h01, 7'h01, 7'h00, 7'h00);
    rd(t2fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0081);
    rd(t2fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0080);
    @(posedge pclk);
    chk(32'(summary_one), 32'h0000_0000);
    $display("Test frame loss done");
    host.xfer(1'b1, t2fcs_pkg::ADDR_STATUS_ONE, 32'h0000_8080);
    for (int k = 0; k < 7; k++)
      ais_exp[k] = (lfsr[4*k +: 4] <= t2fcs_pkg::AIS_E2_MAX_ZEROS);
    repeat (2)
    begin
      @(posedge pclk);
      rx_ais_stb <= 7'h7F;
      @(posedge pclk);
      rx_ais_stb <= 7'h00;
    end
    repeat (3) @(posedge pclk);
    chk(32'(summary_one), 32'(|ais_exp));
    rd(t2fcs_pkg::ADDR_STATUS_ONE, {16'h0000, 1'b1, ais_exp, 8'h80});
    $display("Test all-ones detection done");
    stb(4, 7'h00, 7'h00, 7'h00, 7'h01, 7'h01);
    chk(32'(summary_two), 32'h0000_0000);
    rd(t2fcs_pkg::ADDR_STATUS_TWO, 32'h0000_0001);
    host.xfer(1'b1, t2fcs_pkg::ADDR_STATUS_TWO, 32'h0000_0080);
    stb(4, 7'h00, 7'h00, 7'h00, 7'h01, 7'h00);
    chk(32'(summary_two), 32'h0000_0001);
    rd(t2fcs_pkg::ADDR_STATUS_TWO, 32'h0000_0081);
    rx_national_bit <= 4'h5;
    @(posedge pclk);
    rx_sof_stb <= 4'h6;
    @(posedge pclk);
    rx_sof_stb <= 4'h0;
    repeat (3) @(posedge pclk);
    chk(32'(summary_two), 32'h0000_0000);
    rd(t2fcs_pkg::ADDR_STATUS_TWO, 32'h0000_6480);
    rd(t2fcs_pkg::ADDR_STATUS_TWO, 32'h0000_0480);
    $display("Test remote alarm and frame start done");
    wrap_up();
  end
endmodule
